// [src/chg_host.sv]
/*
  Bus master for the setpoint register bank, commanded over AXI4-Lite.
  Assumes a single slave on the wires; SCL is made by dividing SYS_CLK.
*/
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module chg_host
  import chg_pkg::*;
(
  // System
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // AXI4-Lite
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Bus
  smb_if.master BUS
);
  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_START = 5'h02, H_BIT = 5'h04, H_STOP = 5'h08, H_GAP = 5'h10
  } hstate_e;

  hstate_e st_r;
  logic [1:0] sda_s_r;
  logic [7:0] div_r, reg_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [2:0] byte_r, nbytes_r;
  logic [7:0] tx_r;
  logic [15:0] wd_r, rx_r;
  logic is_rd_r, phase2_r, busy_r, nack_r, scl_oe_r, sda_oe_r;
  logic aw_r, w_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdat_r;

  wire sda_in = sda_s_r[1];
  wire tick = div_r == 8'(HALF_BIT_CYC - 1);
  wire wr_go = aw_r & w_r & ~S_AXI_BVALID;
  wire go_cmd = wr_go & (awaddr_r == OFS_CMD) & ~busy_r;
  wire [2:0] byte_nx = byte_r + 3'd1;
  // Byte that follows the current one: register, low, high
  wire [7:0] next_tx = (byte_nx == 3'd1) ? reg_r : (byte_nx == 3'd2) ? wd_r[7:0] : wd_r[15:8];
  wire [7:0] addr_tx = phase2_r ? ADDR_READ_BYTE : ADDR_WRITE_BYTE;
  wire rx_byte = phase2_r & (byte_r != 3'd0);
  wire [31:0] rd_mux = (S_AXI_ARADDR == OFS_STATUS) ? {30'h0, nack_r, busy_r} :
                       (S_AXI_ARADDR == OFS_RDATA) ? {16'h0, rx_r} :
                       (S_AXI_ARADDR == OFS_WDATA) ? {16'h0, wd_r} : {23'h0, is_rd_r, reg_r};

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      sda_s_r <= 2'b11;
    else
      sda_s_r <= {sda_s_r[0], BUS.sda};
  end

  // AXI write side
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdat_r <= 32'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_r <= 1'b1;
        wdat_r <= S_AXI_WDATA;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awaddr_r == OFS_CMD || awaddr_r == OFS_WDATA) ? 2'b00 : 2'b10;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // AXI read side
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'b00;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Word engine: ph_r 3 SCL low set data, 0 SCL high, 1 sample, 2 SCL low
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= H_IDLE;
      div_r <= 8'h00;
      ph_r <= 2'd0;
      bit_r <= 4'd0;
      byte_r <= 3'd0;
      nbytes_r <= 3'd0;
      tx_r <= 8'h00;
      reg_r <= 8'h00;
      wd_r <= 16'h0;
      rx_r <= 16'h0;
      is_rd_r <= 1'b0;
      phase2_r <= 1'b0;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      div_r <= (tick || st_r == H_IDLE) ? 8'h00 : div_r + 8'h01;
      if (wr_go && awaddr_r == OFS_WDATA && !busy_r)
        wd_r <= wdat_r[15:0];
      case (st_r)
        H_IDLE: begin
          if (go_cmd) begin
            reg_r <= wdat_r[7:0];
            is_rd_r <= wdat_r[8];
            busy_r <= 1'b1;
            nack_r <= 1'b0;
            phase2_r <= 1'b0;
            byte_r <= 3'd0;
            nbytes_r <= wdat_r[8] ? 3'd2 : 3'd4; // R04 R20
            st_r <= H_START;
          end
        end
        H_START: if (tick) begin
          sda_oe_r <= 1'b1;
          st_r <= H_BIT;
          ph_r <= 2'd3;
          bit_r <= 4'd0;
          tx_r <= addr_tx;
        end
        H_BIT: if (tick) begin
          ph_r <= ph_r + 2'd1;
          case (ph_r)
            2'd3: begin
              scl_oe_r <= 1'b1;
              // R01: data bits MSB first, then ack slot
              if (bit_r < 4'd8)
                sda_oe_r <= rx_byte ? 1'b0 : ~tx_r[3'd7 - bit_r[2:0]];
              else
                sda_oe_r <= rx_byte & (byte_r == 3'd1);
            end
            2'd0: scl_oe_r <= 1'b0;
            2'd1: begin
              if (bit_r < 4'd8) begin
                if (rx_byte)
                  rx_r <= (byte_r == 3'd1) ? {rx_r[15:8], rx_r[6:0], sda_in} :
                          {rx_r[14:8], sda_in, rx_r[7:0]}; // R18
              end else if (!rx_byte && sda_in)
                nack_r <= 1'b1;
            end
            2'd2: begin
              scl_oe_r <= 1'b1;
              if (bit_r == 4'd8) begin
                bit_r <= 4'd0;
                byte_r <= byte_r + 3'd1;
                tx_r <= next_tx;
                if (nack_r || byte_r + 3'd1 == nbytes_r) begin
                  st_r <= H_STOP;
                  ph_r <= 2'd0;
                end
              end else
                bit_r <= bit_r + 4'd1;
            end
            default: ph_r <= 2'd0;
          endcase
        end
        H_STOP: if (tick) begin
          ph_r <= ph_r + 2'd1;
          if (ph_r == 2'd0)
            sda_oe_r <= 1'b1;
          else if (ph_r == 2'd1)
            scl_oe_r <= 1'b0;
          else if (ph_r == 2'd2) begin
            sda_oe_r <= 1'b0;
            if (is_rd_r && !phase2_r && !nack_r) begin // Read: pointer, stop, then read
              phase2_r <= 1'b1;
              byte_r <= 3'd0;
              nbytes_r <= 3'd3;
              st_r <= H_GAP;
            end else begin
              busy_r <= 1'b0;
              st_r <= H_IDLE;
            end
          end
        end
        H_GAP: if (tick) begin
          st_r <= H_START;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign BUS.scl_m_oe = scl_oe_r;
  assign BUS.sda_m_oe = sda_oe_r;
endmodule
`default_nettype wire

// [inc/chg_pkg.sv]
/*
  Shared constants for the charger setpoint register bank and its bus master.
  Assumes a 250 MHz system clock on both ends.
*/
`default_nettype none
package chg_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h09;
  localparam logic [7:0] ADDR_WRITE_BYTE = 8'h12;
  localparam logic [7:0] ADDR_READ_BYTE = 8'h13;
  localparam logic [7:0] REG_CURRENT = 8'h14;
  localparam logic [7:0] REG_VOLTAGE = 8'h15;
  localparam logic [7:0] REG_ADAPTER = 8'h3F;
  localparam logic [7:0] REG_MAKER = 8'hFE;
  localparam logic [7:0] REG_PART = 8'hFF;
  localparam logic [15:0] RST_CURRENT = 16'h0000;
  localparam logic [15:0] RST_VOLTAGE = 16'h0000;
  localparam logic [15:0] RST_ADAPTER = 16'h0080;
  localparam logic [15:0] CUR_EN_MIN = 16'h007F;
  localparam logic [15:0] VOLT_EN_MIN = 16'h000F;
  // Voltage DAC code in 16 mV steps: 19.200 V and 1.024 V
  localparam logic [10:0] VDAC_MAX = 11'h4B0;
  localparam logic [10:0] VDAC_MIN = 11'h040;
  localparam logic [5:0] IDAC_TRICKLE = 6'h01;
  localparam int CLK_MHZ = 250;
  localparam int SCL_LOW_MS = 25;
  localparam int NO_WRITE_S = 175;
  localparam longint SCL_LOW_CYC = longint'(SCL_LOW_MS) * CLK_MHZ * 1000;
  localparam longint NO_WRITE_CYC = longint'(NO_WRITE_S) * CLK_MHZ * 1000000;
  // Bus master phase length, system clocks (four phases, SCL period 160 ns)
  localparam int HALF_BIT_CYC = 10;
  // Master register offsets (AXI4-Lite byte addresses)
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_WDATA = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_RDATA = 4'hC;
endpackage
`default_nettype wire

// [inc/smb_if.sv]
/*
  Two-wire bus between the setpoint register bank and its master.
  Assumes open-drain wires with pull-ups; each party drives low via its enable.
*/
`timescale 1ns/1ps
`default_nettype none
interface smb_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  wire scl = ~scl_m_oe;
  wire sda = ~(sda_m_oe | sda_s_oe);
  modport slave (input scl, input sda, output sda_s_oe);
  modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface
`default_nettype wire

// [src/chg_regs.sv]
/*
  Charger setpoint register bank: two-wire slave with word read and write,
  setpoint decode, charge enable, trickle foldback and watchdogs.
  Assumes SCL and SDA come from outside the clock domain.
*/
// Function
// R01: Eight bit bytes, MSB first, then acknowledge
// R02: Slave only, never starts a transaction
// R03: Answers only address bytes 0x12/0x13
// R04: Word write and word read only
// R05: 0x15 is charge voltage register
// R06: 0x14 charge current, 0x3F adapter limit
// R07: Read-only maker and part codes
// R08: Reset loads 0, 0, 0x0080
// R09: Enable needs current >0x7F, voltage >0x0F
// R10: Writing zero disables charging
// R11: Voltage DAC uses bits 14 to 4
// R12: Voltage clamped at 19.200 V
// R13: Below 1.024 V gives zero, stops charging
// R14: Current DAC uses bits 12 to 7
// R15: Current clamped 8.064 A, under 128mA zero; code takes bits 12 to 7 as they are, with no clamp above 0x1F80
// R16: Low battery substitutes 128 mA, hysteresis
// R17: Reads return full value last written
// R18: Low byte first, high byte second
// R19: Watchdogs 175 s and SCL low 25 ms
// R20: One register per write, applied at stop
// R21: Writes to read-only codes ignored
`timescale 1ns/1ps
`default_nettype none
module chg_regs
  import chg_pkg::*;
#(
  parameter logic [15:0] MAKER_VAL = 16'h00A5, // Arbitrary value
  parameter logic [15:0] PART_VAL = 16'h005A, // Arbitrary value
  parameter longint NO_WRITE_LIMIT = NO_WRITE_CYC,
  parameter longint SCL_LOW_LIMIT = SCL_LOW_CYC
) (
  // System
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Bus
  smb_if.slave BUS,
  // Analog status
  input wire logic BATT_LOW,
  input wire logic BATT_HIGH,
  // Setpoint outputs
  output logic [10:0] VOLTAGE_DAC_CODE,
  output logic [5:0] CURRENT_DAC_CODE,
  output logic [5:0] ADAPTER_DAC_CODE,
  output logic CHARGE_EN,
  output logic TRICKLE
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_ADDR = 7'h02, ST_REG = 7'h04, ST_WLO = 7'h08,
    ST_WHI = 7'h10, ST_RD = 7'h20, ST_IGN = 7'h40
  } state_e;

  logic [2:0] scl_s_r, sda_s_r;
  state_e state_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r, ptr_r, wlo_r;
  logic [15:0] cur_r, volt_r, adp_r, pend_r, rd_r;
  logic [7:0] pend_reg_r;
  logic pend_r_v, ack_r, rdsel_r, oe_r, tout_r, trick_r;
  logic [47:0] wd_r, low_r;
  logic [1:0] blow_s_r, bhigh_s_r;

  wire scl_q = scl_s_r[1];
  wire sda_q = sda_s_r[1];
  wire scl_rise = scl_q & ~scl_s_r[2];
  wire scl_fall = ~scl_q & scl_s_r[2];
  wire start_c = scl_q & scl_s_r[2] & ~sda_q & sda_s_r[2];
  wire stop_c = scl_q & scl_s_r[2] & sda_q & ~sda_s_r[2];
  wire [7:0] sh_in = {sh_r[6:0], sda_q}; // R01
  wire byte_done = scl_rise & (bit_r == 4'd7);
  wire ack_slot = bit_r == 4'd8;
  wire addr_hit_w = sh_in == ADDR_WRITE_BYTE; // R03
  wire addr_hit_r = sh_in == ADDR_READ_BYTE;
  wire [15:0] rd_word = (ptr_r == REG_CURRENT) ? cur_r :
                        (ptr_r == REG_VOLTAGE) ? volt_r :
                        (ptr_r == REG_ADAPTER) ? adp_r :
                        (ptr_r == REG_MAKER) ? MAKER_VAL :
                        (ptr_r == REG_PART) ? PART_VAL : 16'h0000; // R07 R17
  wire commit = stop_c & pend_r_v; // R20
  wire sp_write = commit & (pend_reg_r == REG_CURRENT || pend_reg_r == REG_VOLTAGE);
  // R11 R12 R13
  wire [10:0] v_raw = volt_r[14:4];
  wire [10:0] v_code = (v_raw > VDAC_MAX) ? VDAC_MAX : (v_raw < VDAC_MIN) ? 11'h000 : v_raw;
  wire [5:0] i_code = cur_r[12:7]; // R14 R15
  wire trick_nxt = blow_s_r[1] ? 1'b1 : bhigh_s_r[1] ? 1'b0 : trick_r; // R16
  wire en_nxt = (cur_r > CUR_EN_MIN) & (volt_r > VOLT_EN_MIN) & (v_code != 11'h000)
                & ~tout_r; // R09 R10 R13
  wire wd_exp = wd_r >= NO_WRITE_LIMIT[47:0];
  wire low_exp = low_r >= SCL_LOW_LIMIT[47:0];

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_s_r <= 3'b111;
      sda_s_r <= 3'b111;
      blow_s_r <= 2'b00;
      bhigh_s_r <= 2'b00;
    end else begin
      scl_s_r <= {scl_s_r[1:0], BUS.scl};
      sda_s_r <= {sda_s_r[1:0], BUS.sda};
      // Comparator levels come from the analog side
      blow_s_r <= {blow_s_r[0], BATT_LOW};
      bhigh_s_r <= {bhigh_s_r[0], BATT_HIGH};
    end
  end

  // Byte engine: slave only, acts on the master's clock edges
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin // R02
    if (!RESET_N) begin
      state_r <= ST_IDLE;
      bit_r <= 4'd0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      wlo_r <= 8'h00;
      pend_r <= 16'h0000;
      pend_reg_r <= 8'h00;
      pend_r_v <= 1'b0;
      ack_r <= 1'b0;
      rdsel_r <= 1'b0;
      rd_r <= 16'h0000;
      oe_r <= 1'b0;
    end else if (start_c) begin
      state_r <= ST_ADDR;
      bit_r <= 4'd0;
      pend_r_v <= 1'b0;
      oe_r <= 1'b0;
    end else if (stop_c) begin
      state_r <= ST_IDLE;
      pend_r_v <= 1'b0;
      oe_r <= 1'b0;
    end else if (scl_rise) begin
      if (ack_slot) begin
        bit_r <= 4'd0;
        // ack_r high marks our own acknowledge (in ST_RD only the address one), not the master's
        if (state_r == ST_RD && !ack_r && (sda_q || rdsel_r))
          state_r <= ST_IGN; // Master NACK or second byte done
        else if (state_r == ST_RD && !ack_r)
          rdsel_r <= 1'b1;
      end else begin
        bit_r <= bit_r + 4'd1;
        sh_r <= sh_in;
      end
      if (byte_done) begin
        ack_r <= 1'b1;
        case (state_r)
          ST_ADDR: begin
            if (addr_hit_w)
              state_r <= ST_REG;
            else if (addr_hit_r) begin // R04
              state_r <= ST_RD;
              rd_r <= rd_word;
              rdsel_r <= 1'b0;
              ack_r <= 1'b1;
            end else begin
              state_r <= ST_IGN;
              ack_r <= 1'b0;
            end
          end
          ST_REG: begin
            ptr_r <= sh_in;
            state_r <= ST_WLO;
          end
          ST_WLO: begin
            wlo_r <= sh_in; // R18
            state_r <= ST_WHI;
          end
          ST_WHI: begin
            pend_r <= {sh_in, wlo_r};
            pend_reg_r <= ptr_r;
            pend_r_v <= 1'b1;
            state_r <= ST_IGN; // Further bytes refused
          end
          ST_RD: ack_r <= 1'b0;
          default: ack_r <= 1'b0;
        endcase
        if (state_r == ST_IGN)
          ack_r <= 1'b0;
      end
    end else if (scl_fall) begin
      if (ack_slot)
        oe_r <= ack_r;
      else if (state_r == ST_RD)
        oe_r <= ~(rdsel_r ? rd_r[4'd15 - bit_r] : rd_r[4'd7 - bit_r]); // R01 R18
      else
        oe_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cur_r <= RST_CURRENT; // R08
      volt_r <= RST_VOLTAGE;
      adp_r <= RST_ADAPTER;
    end else if (commit) begin
      if (pend_reg_r == REG_CURRENT)
        cur_r <= pend_r; // R06
      if (pend_reg_r == REG_VOLTAGE)
        volt_r <= pend_r; // R05
      if (pend_reg_r == REG_ADAPTER)
        adp_r <= pend_r; // R06 R21
    end
  end

  // Watchdogs
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wd_r <= 48'd0;
      low_r <= 48'd0;
      tout_r <= 1'b0;
    end else begin
      wd_r <= sp_write ? 48'd0 : (wd_exp ? wd_r : wd_r + 48'd1);
      low_r <= scl_q ? 48'd0 : (low_exp ? low_r : low_r + 48'd1);
      tout_r <= sp_write ? 1'b0 : (tout_r | wd_exp | low_exp); // R19
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trick_r <= 1'b0;
      VOLTAGE_DAC_CODE <= 11'h000;
      CURRENT_DAC_CODE <= 6'h00;
      ADAPTER_DAC_CODE <= 6'h00;
      CHARGE_EN <= 1'b0;
      TRICKLE <= 1'b0;
    end else begin
      trick_r <= trick_nxt;
      VOLTAGE_DAC_CODE <= en_nxt ? v_code : 11'h000;
      CURRENT_DAC_CODE <= !en_nxt ? 6'h00 : trick_nxt ? IDAC_TRICKLE : i_code; // R16
      ADAPTER_DAC_CODE <= adp_r[12:7];
      CHARGE_EN <= en_nxt;
      TRICKLE <= trick_nxt;
    end
  end

  assign BUS.sda_s_oe = oe_r;
endmodule
`default_nettype wire

// [testbench/smb_bus_assertions.sv]
/*
  Checker for the two-wire bus between register bank and host.
  Assumes scl and sda are the wired levels, sampled on SYS_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module smb_bus_checker
  import chg_pkg::*;
(
  // System
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe
);
  logic scl_q_r;
  logic sda_q_r;
  logic rd_r;
  logic [3:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [7:0] sh_r;
  wire scl_rise = scl && !scl_q_r;
  wire start_c = scl && scl_q_r && sda_q_r && !sda;
  wire stop_c = scl && scl_q_r && !sda_q_r && sda;

  // Bit and byte position since the last start
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      rd_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      byte_cnt_r <= 3'h0;
      sh_r <= 8'h00;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      if (start_c) begin
        bit_cnt_r <= 4'h0;
        byte_cnt_r <= 3'h0;
        rd_r <= 1'b0;
      end else if (scl_rise) begin
        bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
        byte_cnt_r <= (bit_cnt_r == 4'h8) ? byte_cnt_r + 3'h1 : byte_cnt_r;
        sh_r <= (bit_cnt_r == 4'h8) ? sh_r : {sh_r[6:0], sda};
        rd_r <= (byte_cnt_r == 3'h0 && bit_cnt_r == 4'h7) ? sda : rd_r;
      end
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence ninth_rise;
    scl_rise && bit_cnt_r == 4'h8;
  endsequence

  slave_hold_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data changed while clock high");
  ack_slot_a: assert property (scl_rise && sda_s_oe && !rd_r |-> bit_cnt_r == 4'h8)
    else $error("slave drove data outside the acknowledge slot");
  start_free_a: assert property (start_c |-> !sda_s_oe)
    else $error("slave drove data at a start");
  stop_free_a: assert property (stop_c |-> !sda_s_oe)
    else $error("slave drove data at a stop");
  addr_ack_a: assert property (ninth_rise ##0 (byte_cnt_r == 3'h0 &&
    (sh_r == ADDR_WRITE_BYTE || sh_r == ADDR_READ_BYTE)) |-> !sda)
    else $error("own address not acknowledged");
  write_ack_a: assert property (ninth_rise ##0 (!rd_r && byte_cnt_r != 3'h0) |-> !sda)
    else $error("write byte not acknowledged");
  low_ack_a: assert property (ninth_rise ##0 (rd_r && byte_cnt_r == 3'h1) |-> !sda)
    else $error("low read byte not acknowledged");
  high_nack_a: assert property (ninth_rise ##0 (rd_r && byte_cnt_r == 3'h2) |-> sda)
    else $error("high read byte not refused");
endmodule
`default_nettype wire

// [testbench/testbench.sv]
/*
  Testbench: host and register bank joined by the bus interface.
  Assumes software commands through the host's AXI4-Lite registers.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench import chg_pkg::*; ;
  localparam logic [15:0] MAKER_T = 16'h00C3; // Arbitrary value
  localparam logic [15:0] PART_T = 16'h003C; // Arbitrary value
  localparam longint NW_LIM = 20000;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic batt_low = 1'b0;
  logic batt_high = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [10:0] vdac;
  wire logic [5:0] idac, adac;
  wire logic chg_en, trickle;
  int n_mismatch = 0;
  int check_count = 0;
  smb_if bus ();

  chg_host chg_host_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .BUS(bus));
  chg_regs #(.MAKER_VAL(MAKER_T), .PART_VAL(PART_T), .NO_WRITE_LIMIT(NW_LIM),
    .SCL_LOW_LIMIT(64'd2000)) chg_regs_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .BUS(bus), .BATT_LOW(batt_low), .BATT_HIGH(batt_high), .VOLTAGE_DAC_CODE(vdac),
    .CURRENT_DAC_CODE(idac), .ADAPTER_DAC_CODE(adac), .CHARGE_EN(chg_en), .TRICKLE(trickle));
  smb_bus_checker chk (.SYS_CLK(sys_clk), .RESET_N(reset_n), .scl(bus.scl), .sda(bus.sda),
    .sda_s_oe(bus.sda_s_oe));

  always #2 sys_clk = ~sys_clk;

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic expire;
    n_mismatch++;
    $display("[ERR] %0t wait limit reached", $time);
    give_verdict();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    logic [1:0] br;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    for (int n = 0; n < 100 && !bh; n++) begin
      @(negedge sys_clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bready && bvalid;
      br = bresp;
      @(posedge sys_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    check(br, (a == OFS_CMD || a == OFS_WDATA) ? 2'b00 : 2'b10);
    if (!bh) expire();
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    logic ah, rh;
    logic [1:0] rr;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    for (int n = 0; n < 100 && !rh; n++) begin
      @(negedge sys_clk);
      ah = arvalid && arready;
      rh = rready && rvalid;
      d = rdata;
      rr = rresp;
      @(posedge sys_clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
    check(rr, 2'b00);
    if (!rh) expire();
  endtask

  task automatic host_cmd(input logic rd, input logic [7:0] rg);
    logic [31:0] st;
    axi_write(OFS_CMD, {23'h0, rd, rg});
    repeat (4) @(posedge sys_clk);
    st = 32'h1;
    for (int n = 0; n < 2000 && st[0] !== 1'b0; n++) axi_read(OFS_STATUS, st);
    if (st[0] !== 1'b0) expire();
    check(st[1], 1'b0);
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic smb_wr(input logic [7:0] rg, input logic [15:0] v);
    axi_write(OFS_WDATA, {16'h0, v});
    host_cmd(1'b0, rg);
  endtask

  task automatic smb_rd(input logic [7:0] rg, input logic [15:0] exp);
    logic [31:0] d;
    host_cmd(1'b1, rg);
    axi_read(OFS_RDATA, d);
    check(d[15:0], exp);
  endtask

  function automatic logic [10:0] vexp(input logic [15:0] v);
    if (v[14:4] > VDAC_MAX) return VDAC_MAX;
    if (v[14:4] < VDAC_MIN) return 11'h000;
    return v[14:4];
  endfunction

  logic [7:0] rgs [5] = '{REG_CURRENT, REG_VOLTAGE, REG_ADAPTER, REG_MAKER, REG_PART};
  logic [15:0] rst [5] = '{RST_CURRENT, RST_VOLTAGE, RST_ADAPTER, MAKER_T, PART_T};
  logic [15:0] vv [6] = '{16'h1000, 16'hFFFF, 16'h4B00, 16'h8400, 16'h03F0, 16'h0400};
  logic [15:0] cv [5] = '{16'h007F, 16'h0080, 16'hFFFF, 16'h1F80, 16'h0000};

  task automatic t_reset;
    repeat (3) @(negedge sys_clk);
    check(chg_en, 1'b0);
    check(adac, RST_ADAPTER[12:7]);
    for (int i = 0; i < 5; i++) smb_rd(rgs[i], rst[i]);
  endtask

  task automatic t_ids;
    axi_write(OFS_STATUS, 32'h0);
    smb_wr(REG_MAKER, 16'h1234);
    smb_wr(REG_PART, 16'hABCD);
    smb_rd(REG_MAKER, MAKER_T);
    smb_rd(REG_PART, PART_T);
  endtask

  task automatic t_voltage;
    smb_wr(REG_CURRENT, 16'h0080);
    check(chg_en, 1'b0);
    for (int i = 0; i < 6; i++) begin
      smb_wr(REG_VOLTAGE, vv[i]);
      check(vdac, vexp(vv[i]));
      check(chg_en, vexp(vv[i]) != 11'h000);
      smb_rd(REG_VOLTAGE, vv[i]);
    end
  endtask

  task automatic t_current;
    smb_wr(REG_VOLTAGE, 16'h4B00);
    for (int i = 0; i < 5; i++) begin
      smb_wr(REG_CURRENT, cv[i]);
      check(chg_en, cv[i] > CUR_EN_MIN);
      check(idac, (cv[i] > CUR_EN_MIN) ? cv[i][12:7] : 6'h00);
      check(adac, RST_ADAPTER[12:7]);
    end
  endtask

  task automatic t_adapter;
    smb_wr(REG_ADAPTER, 16'h0F80);
    check(adac, 6'h1F);
    smb_rd(REG_ADAPTER, 16'h0F80);
  endtask

  task automatic wait_trickle(input logic lvl);
    for (int n = 0; n < 50 && trickle !== lvl; n++) @(posedge sys_clk);
    if (trickle !== lvl) expire();
  endtask

  task automatic t_trickle;
    smb_wr(REG_CURRENT, 16'hFFFF);
    batt_low <= 1'b1;
    wait_trickle(1'b1);
    repeat (3) @(posedge sys_clk);
    check(idac, IDAC_TRICKLE);
    batt_low <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check(trickle, 1'b1);
    batt_high <= 1'b1;
    wait_trickle(1'b0);
    repeat (3) @(posedge sys_clk);
    check(idac, 6'h3F);
    batt_high <= 1'b0;
    smb_rd(REG_CURRENT, 16'hFFFF);
  endtask

  task automatic t_timeout;
    check(chg_en, 1'b1);
    for (int n = 0; n < NW_LIM + 2000 && chg_en !== 1'b0; n++) @(posedge sys_clk);
    check(chg_en, 1'b0);
    smb_wr(REG_VOLTAGE, 16'h4B00);
    check(chg_en, 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_ids();
    t_voltage();
    t_current();
    t_adapter();
    t_trickle();
    t_timeout();
    give_verdict();
  end
endmodule
`default_nettype wire
